/* File: design/pd_rx_regs.svh */
// Register indices, field positions, reset values and timing counts of the receive status bank
`ifndef PD_RX_REGS_SVH
`define PD_RX_REGS_SVH

// Register indices; byte address on the bus is four times the index
`define IDX_PKT_STAT      16'h1A45
`define IDX_CRC_TIMEOUT   16'h1A46
`define IDX_BAD_COUNT     16'h1A47
`define IDX_DUP_COUNT     16'h1A48
`define IDX_RESET_WINDOW  16'h1A49
`define IDX_MAX_SIZE      16'h1A4D
`define IDX_MODE_CTRL     16'h1A4E

// Packet status field positions
`define PS_ODD_NIBBLES    6
`define PS_SYMBOL_ERROR   5
`define PS_FIFO_FULL      4
`define PS_OVER_SIZE      3
`define PS_UNEXPECTED     2
`define PS_DUPLICATE      1
`define PS_BAD_CRC        0

// Mode control field positions
`define MC_AUTO_RESPONSE  0
`define MC_AUTO_RETRY     1
`define MC_BIST_RX        2

// Reset values and codes
`define RST_PKT_STAT      8'h00
`define PKT_STAT_UNKNOWN  8'hFF
`define RST_CRC_TIMEOUT   8'h64
`define RST_COUNT         8'h00
`define RST_RESET_WINDOW  7'h5E
`define RST_MAX_SIZE      8'h22
`define RST_MODE_CTRL     8'h00
`define COUNT_LIMIT       8'h7F
`define COUNT_MAX         8'hFF

// Timing: one microsecond tick from a 25 ns clock, timeout unit of 10 us
`define CLK_PERIOD_PS     25000
`define TICK_PS           1000000
`define TICK_CYCLES       (`TICK_PS / `CLK_PERIOD_PS)
`define CRC_UNIT_US       10

`endif

/* File: design/pd_rx_pkg.sv */
// Types shared by the receive status bank and its timeout timer
package pd_rx_pkg;

	typedef struct packed {
		logic       sop_start;
		logic       pkt_done;
		logic       sop_valid;
		logic       odd_nibbles;
		logic       symbol_error;
		logic       bad_crc;
		logic       invalid_eop;
		logic       fifo_full;
		logic       goodcrc_expected;
		logic       msg_is_goodcrc;
		logic       msg_is_ping;
		logic       duplicate;
		logic [7:0] byte_count;
	} rx_event_t;

	typedef struct packed {
		logic bad_packet;
		logic buffer_overrun;
		logic protocol_error;
		logic packet_dropped;
		logic debug_event;
	} rx_irq_t;

	typedef enum logic [0:0] {
		TIMER_IDLE = 1'b0,
		TIMER_RUN  = 1'b1
	} timer_state_t;

endpackage

/* File: design/crc_receive_timer.sv */
// CRC receive timer paced by a free running one microsecond tick
`timescale 1ns/100ps
`include "pd_rx_regs.svh"
module crc_receive_timer #(
	parameter int TICK_CYCLES = `TICK_CYCLES
) (
	input  wire logic       clock,
	input  wire logic       srst,
	input  wire logic       start,
	input  wire logic       cancel,
	input  wire logic [7:0] timeout_value,
	output logic            timeout,
	output logic            running
);
	import pd_rx_pkg::*;

	localparam int DIV_W = $clog2(TICK_CYCLES);
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);

	logic [DIV_W-1:0] div_q;
	logic             tick_q;
	logic [11:0]      remain_q;
	timer_state_t     state_q;

	// Tick never restarts, so the first tick of a run may come early
	always_ff @(posedge clock) begin
		if (srst) begin
			div_q  <= '0;
			tick_q <= 1'b0;
		end else begin
			tick_q <= (div_q == DIV_LAST);
			div_q  <= (div_q == DIV_LAST) ? '0 : div_q + 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			state_q  <= TIMER_IDLE;
			remain_q <= 12'h000;
			timeout  <= 1'b0;
		end else begin
			timeout <= 1'b0;
			case (state_q)
				TIMER_IDLE: begin
					if (start) begin
						remain_q <= 12'(timeout_value * `CRC_UNIT_US);
						state_q  <= TIMER_RUN;
					end
				end
				TIMER_RUN: begin
					if (cancel) begin
						state_q <= TIMER_IDLE;
					end else if (tick_q) begin
						// A zero value expires on the first tick
						if (remain_q <= 12'h001) begin
							timeout <= 1'b1;
							state_q <= TIMER_IDLE;
						end else begin
							remain_q <= remain_q - 12'h001;
						end
					end
				end
				default: state_q <= TIMER_IDLE;
			endcase
		end
	end

	assign running = (state_q == TIMER_RUN);

endmodule // crc_receive_timer

/* File: design/pd_rx_status.sv */
// Receive packet status, debug counters and timing settings behind an Avalon-MM slave
// Function
// - Packet status is reported only in auto-response or auto-retry mode
// - Once any status bit is set, hardware holds it until software clears
// - Status 0x00 means no errors, 0xFF means status not yet known
// - Hardware sets status bits, software clears them; several may be set
// - Odd nibble count: drop packet, set bit 6, bad-packet interrupt
// - Symbol error without bad CRC: set bit 5, bad-packet interrupt
// - Oversize packet leaves odd-nibble, symbol and bad-CRC bits clear
// - FIFO full at start or data: drop, set bit 4, overrun interrupt
// - Packet above maximum size: drop, set bit 3, bad-packet interrupt
// - Non GoodCRC or Ping while GoodCRC expected: bit 2, protocol interrupt
// - Duplicate in auto-response mode: set bit 1, packet-dropped interrupt
// - Bad CRC sets bit 0; symbol error or odd nibbles force it too
// - CRC receive timeout is the programmed value times 10 us
// - Timeout uses free running 1 us tick, may run one tick short
// - Bad packet counter counts valid-start packets with CRC, EOP or symbol errors
// - Either counter above 127 raises the debug event flag
// - Any write to a debug counter with byte lane 0 enabled clears it; a count in the same cycle then adds one
// - Packets during receiver self-test leave bad packet counter alone
// - Duplicate counter counts duplicates only in auto-response mode
// - Seven-bit reset detection window in bit times, resets to 1011110b
// - Maximum packet size includes four CRC bytes, resets to 22h
`timescale 1ns/100ps
`include "pd_rx_regs.svh"
module pd_rx_status #(
	parameter int ADDR_W      = 16,
	parameter int TICK_CYCLES = `TICK_CYCLES
) (
	input  wire logic              clock,
	input  wire logic              srst,
	input  wire logic [ADDR_W-1:0] address,
	input  wire logic              read,
	input  wire logic              write,
	input  wire logic [31:0]       writedata,
	input  wire logic [3:0]        byteenable,
	output logic [31:0]            readdata,
	output logic                   waitrequest,
	input  wire pd_rx_pkg::rx_event_t rx_event,
	input  wire logic              crc_timer_start,
	input  wire logic              crc_timer_cancel,
	output logic                   crc_timeout,
	output pd_rx_pkg::rx_irq_t     irq,
	output logic                   packet_drop,
	output logic [6:0]             link_reset_detect_window,
	output logic [7:0]             max_packet_size
);
	import pd_rx_pkg::*;

	logic [7:0]  packet_error_status_q;
	logic [7:0]  packet_error_status_d;
	logic [7:0]  crc_receive_timeout_value_q;
	logic [7:0]  bad_packet_count_q;
	logic [7:0]  duplicate_packet_count_q;
	logic [7:0]  mode_ctrl_q;
	logic [31:0] readdata_q;
	logic        waitrequest_q;
	rx_irq_t     irq_q;
	logic        packet_drop_q;
	logic [6:0]  window_q;
	logic [7:0]  max_size_q;

	logic        wr_take;
	logic        wr_lane0;
	logic [7:0]  wr_byte;
	logic        auto_response_en;
	logic        status_mode;
	logic        over_size;
	logic        unexpected_msg;
	logic [7:0]  new_bits;
	logic        status_open;
	logic        bad_inc;
	logic        dup_inc;
	logic [7:0]  bad_count_d;
	logic [7:0]  dup_count_d;
	logic        wr_pkt_stat;
	logic        wr_crc_timeout;
	logic        wr_bad_count;
	logic        wr_dup_count;
	logic        wr_window;
	logic        wr_max_size;
	logic        wr_mode_ctrl;

	// Word index match for a byte address
	function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [15:0] idx);
		logic [ADDR_W-1:0] word;
		word = addr >> 2;
		hit  = (word == ADDR_W'(idx));
	endfunction

	// Counter step: increment saturates, a same-cycle count is added after the clear
	function automatic logic [7:0] next_count(
		input logic [7:0] cnt,
		input logic       inc,
		input logic       clr
	);
		logic [7:0] base;
		base = clr ? 8'h00 : cnt;
		if (inc && base != `COUNT_MAX) begin
			next_count = base + 8'h01;
		end else begin
			next_count = base;
		end
	endfunction

	// Bus side

	// A write lands only at the edge where waitrequest is seen low
	assign wr_take  = write && !waitrequest_q;
	assign wr_lane0 = wr_take && byteenable[0];
	assign wr_byte  = writedata[7:0];

	// Write decode: one strobe per register, only at the accepting edge
	always_comb begin
		wr_pkt_stat    = 1'b0;
		wr_crc_timeout = 1'b0;
		wr_bad_count   = 1'b0;
		wr_dup_count   = 1'b0;
		wr_window      = 1'b0;
		wr_max_size    = 1'b0;
		wr_mode_ctrl   = 1'b0;
		if (wr_lane0) begin
			if (hit(address, `IDX_PKT_STAT)) begin
				wr_pkt_stat = 1'b1;
			end else if (hit(address, `IDX_CRC_TIMEOUT)) begin
				wr_crc_timeout = 1'b1;
			end else if (hit(address, `IDX_BAD_COUNT)) begin
				wr_bad_count = 1'b1;
			end else if (hit(address, `IDX_DUP_COUNT)) begin
				wr_dup_count = 1'b1;
			end else if (hit(address, `IDX_RESET_WINDOW)) begin
				wr_window = 1'b1;
			end else if (hit(address, `IDX_MAX_SIZE)) begin
				wr_max_size = 1'b1;
			end else if (hit(address, `IDX_MODE_CTRL)) begin
				wr_mode_ctrl = 1'b1;
			end
		end
	end

	// One wait state per access; the answer stands for exactly one cycle
	always_ff @(posedge clock) begin
		if (srst) begin
			waitrequest_q <= 1'b1;
		end else if ((read || write) && waitrequest_q) begin
			waitrequest_q <= 1'b0;
		end else begin
			waitrequest_q <= 1'b1;
		end
	end

	// Read data is captured with the request and held until the next read
	always_ff @(posedge clock) begin
		if (srst) begin
			readdata_q <= 32'h0000_0000;
		end else if (read && waitrequest_q) begin
			if (hit(address, `IDX_PKT_STAT)) begin
				readdata_q <= {24'h00_0000, packet_error_status_q};
			end else if (hit(address, `IDX_CRC_TIMEOUT)) begin
				readdata_q <= {24'h00_0000, crc_receive_timeout_value_q};
			end else if (hit(address, `IDX_BAD_COUNT)) begin
				readdata_q <= {24'h00_0000, bad_packet_count_q};
			end else if (hit(address, `IDX_DUP_COUNT)) begin
				readdata_q <= {24'h00_0000, duplicate_packet_count_q};
			end else if (hit(address, `IDX_RESET_WINDOW)) begin
				readdata_q <= {25'h000_0000, window_q};
			end else if (hit(address, `IDX_MAX_SIZE)) begin
				readdata_q <= {24'h00_0000, max_size_q};
			end else if (hit(address, `IDX_MODE_CTRL)) begin
				readdata_q <= {24'h00_0000, mode_ctrl_q};
			end else begin
				readdata_q <= 32'h0000_0000;
			end
		end
	end

	// Plain read/write settings

	always_ff @(posedge clock) begin
		if (srst) begin
			crc_receive_timeout_value_q <= `RST_CRC_TIMEOUT;
		end else if (wr_crc_timeout) begin
			// Zero is accepted as written; the timer then expires on its first tick
			crc_receive_timeout_value_q <= wr_byte;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			window_q <= `RST_RESET_WINDOW;
		end else if (wr_window) begin
			window_q <= wr_byte[6:0];
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			max_size_q <= `RST_MAX_SIZE;
		end else if (wr_max_size) begin
			max_size_q <= wr_byte;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			mode_ctrl_q <= `RST_MODE_CTRL;
		end else if (wr_mode_ctrl) begin
			mode_ctrl_q <= {5'b00000, wr_byte[2:0]};
		end
	end

	// Packet classification

	assign auto_response_en = mode_ctrl_q[`MC_AUTO_RESPONSE];
	assign status_mode      = mode_ctrl_q[`MC_AUTO_RESPONSE] || mode_ctrl_q[`MC_AUTO_RETRY];

	// Byte count includes the CRC bytes, as does the limit
	assign over_size      = rx_event.byte_count > max_size_q;
	assign unexpected_msg = rx_event.goodcrc_expected
		&& !rx_event.msg_is_goodcrc && !rx_event.msg_is_ping;

	always_comb begin
		new_bits = 8'h00;
		new_bits[`PS_OVER_SIZE] = over_size;
		if (!over_size) begin
			new_bits[`PS_ODD_NIBBLES]  = rx_event.odd_nibbles;
			new_bits[`PS_SYMBOL_ERROR] = rx_event.symbol_error && !rx_event.bad_crc;
			new_bits[`PS_BAD_CRC]      = rx_event.bad_crc || rx_event.symbol_error
				|| rx_event.odd_nibbles;
		end
		new_bits[`PS_ODD_NIBBLES] = new_bits[`PS_ODD_NIBBLES] && !over_size;
		new_bits[`PS_FIFO_FULL]   = rx_event.fifo_full;
		new_bits[`PS_UNEXPECTED]  = unexpected_msg;
		new_bits[`PS_DUPLICATE]   = rx_event.duplicate && auto_response_en;
	end

	// Packet status register

	// Hardware may write only while the field is clear or still unknown
	assign status_open = (packet_error_status_q == `RST_PKT_STAT)
		|| (packet_error_status_q == `PKT_STAT_UNKNOWN);

	// A hardware load beats a software clear in the same cycle
	always_comb begin
		packet_error_status_d = packet_error_status_q;
		if (wr_pkt_stat) begin
			packet_error_status_d = packet_error_status_q & ~wr_byte;
		end
		if (status_mode && status_open) begin
			if (rx_event.pkt_done) begin
				packet_error_status_d = new_bits;
			end else if (rx_event.sop_start
				&& packet_error_status_q == `RST_PKT_STAT) begin
				packet_error_status_d = `PKT_STAT_UNKNOWN;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			packet_error_status_q <= `RST_PKT_STAT;
		end else begin
			packet_error_status_q <= packet_error_status_d;
		end
	end

	// Debug counters

	assign bad_inc = rx_event.pkt_done && rx_event.sop_valid
		&& (rx_event.bad_crc || rx_event.invalid_eop || rx_event.symbol_error)
		&& !mode_ctrl_q[`MC_BIST_RX];
	assign dup_inc = rx_event.pkt_done && rx_event.duplicate && auto_response_en;

	assign bad_count_d = next_count(bad_packet_count_q, bad_inc,
		wr_bad_count);
	assign dup_count_d = next_count(duplicate_packet_count_q, dup_inc,
		wr_dup_count);

	always_ff @(posedge clock) begin
		if (srst) begin
			bad_packet_count_q <= `RST_COUNT;
		end else begin
			bad_packet_count_q <= bad_count_d;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			duplicate_packet_count_q <= `RST_COUNT;
		end else begin
			duplicate_packet_count_q <= dup_count_d;
		end
	end

	// Interrupt events, one-cycle pulses to the interrupt status block

	always_ff @(posedge clock) begin
		if (srst) begin
			irq_q         <= '0;
			packet_drop_q <= 1'b0;
		end else begin
			irq_q.bad_packet <= status_mode && rx_event.pkt_done
				&& (new_bits[`PS_ODD_NIBBLES] || new_bits[`PS_SYMBOL_ERROR]
				|| new_bits[`PS_OVER_SIZE] || new_bits[`PS_BAD_CRC]);
			irq_q.buffer_overrun <= status_mode && rx_event.pkt_done
				&& new_bits[`PS_FIFO_FULL];
			irq_q.protocol_error <= status_mode && rx_event.pkt_done
				&& new_bits[`PS_UNEXPECTED];
			irq_q.packet_dropped <= status_mode && rx_event.pkt_done
				&& new_bits[`PS_DUPLICATE];
			// Fires once as a counter crosses from 127 to 128
			irq_q.debug_event <=
				(bad_count_d > `COUNT_LIMIT && bad_packet_count_q <= `COUNT_LIMIT)
				|| (dup_count_d > `COUNT_LIMIT && duplicate_packet_count_q <= `COUNT_LIMIT);
			packet_drop_q <= status_mode && rx_event.pkt_done
				&& (new_bits[`PS_ODD_NIBBLES] || new_bits[`PS_FIFO_FULL]
				|| new_bits[`PS_OVER_SIZE]);
		end
	end

	// CRC receive timer

	crc_receive_timer #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_crc_timer (
		.clock         (clock),
		.srst          (srst),
		.start         (crc_timer_start),
		.cancel        (crc_timer_cancel),
		.timeout_value (crc_receive_timeout_value_q),
		.timeout       (crc_timeout),
		.running       ()
	);

	assign readdata                 = readdata_q;
	assign waitrequest              = waitrequest_q;
	assign irq                      = irq_q;
	assign packet_drop              = packet_drop_q;
	assign link_reset_detect_window = window_q;
	assign max_packet_size          = max_size_q;

endmodule // pd_rx_status

/* File: sim/pd_rx_status_properties.sv */
// Port-level checks for the receive status bank
`timescale 1ns/100ps
`include "pd_rx_regs.svh"
module pd_rx_status_properties #(
	parameter int ADDR_W      = 16,
	parameter int TICK_CYCLES = 40
) (
	input wire logic                 clock,
	input wire logic                 srst,
	input wire logic [ADDR_W-1:0]    address,
	input wire logic                 read,
	input wire logic                 write,
	input wire logic [31:0]          writedata,
	input wire logic [3:0]           byteenable,
	input wire logic [31:0]          readdata,
	input wire logic                 waitrequest,
	input wire pd_rx_pkg::rx_event_t rx_event,
	input wire logic                 crc_timer_start,
	input wire logic                 crc_timer_cancel,
	input wire logic                 crc_timeout,
	input wire pd_rx_pkg::rx_irq_t   irq,
	input wire logic                 packet_drop,
	input wire logic [6:0]           link_reset_detect_window,
	input wire logic [7:0]           max_packet_size
);
	import pd_rx_pkg::*;
	logic [2:0] mode_q;
	logic [7:0] wd_q;
	logic       acc;
	logic       on;
	logic       done;
	// Mode is shadowed from bus writes since the register itself is not visible here
	assign acc = write && !waitrequest && byteenable[0];
	assign on = mode_q[0] || mode_q[1];
	assign done = rx_event.pkt_done && on;
	always_ff @(posedge clock) begin
		if (srst)
			mode_q <= '0;
		else if (acc && address == (`IDX_MODE_CTRL << 2))
			mode_q <= writedata[2:0];
	end
	always_ff @(posedge clock)
		wd_q <= writedata[7:0];
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	property p_answer; (read || write) && waitrequest |=> !waitrequest; endproperty
	a_answer: assert property (p_answer) else $error("bus access not answered");
	property p_odd; done && rx_event.odd_nibbles |=> irq.bad_packet && packet_drop; endproperty
	a_odd: assert property (p_odd) else $error("odd nibble packet not dropped");
	property p_fifo; done && rx_event.fifo_full |=> irq.buffer_overrun && packet_drop; endproperty
	a_fifo: assert property (p_fifo) else $error("full fifo packet not dropped");
	property p_size;
		done && rx_event.byte_count > max_packet_size |=> irq.bad_packet && packet_drop;
	endproperty
	a_size: assert property (p_size) else $error("oversize packet not dropped");
	property p_unexp;
		done && rx_event.goodcrc_expected && !rx_event.msg_is_goodcrc && !rx_event.msg_is_ping
			|=> irq.protocol_error;
	endproperty
	a_unexp: assert property (p_unexp) else $error("protocol error missed");
	property p_dup; rx_event.pkt_done && rx_event.duplicate && mode_q[0] |=> irq.packet_dropped;
	endproperty
	a_dup: assert property (p_dup) else $error("duplicate not flagged");
	property p_rst;
		$past(srst) |-> link_reset_detect_window == `RST_RESET_WINDOW
			&& max_packet_size == `RST_MAX_SIZE;
	endproperty
	a_rst: assert property (p_rst) else $error("wrong value after reset");
	property p_win;
		acc && address == (`IDX_RESET_WINDOW << 2) |=> link_reset_detect_window == wd_q[6:0];
	endproperty
	a_win: assert property (p_win) else $error("window write lost");
	property p_max; acc && address == (`IDX_MAX_SIZE << 2) |=> max_packet_size == wd_q;
	endproperty
	a_max: assert property (p_max) else $error("max size write lost");
	property p_cancel; crc_timer_cancel |=> !crc_timeout; endproperty
	a_cancel: assert property (p_cancel) else $error("timeout after cancel");
	cover property (irq.debug_event);
	cover property (crc_timeout);
	cover property (packet_drop);
endmodule // pd_rx_status_properties
bind pd_rx_status pd_rx_status_properties #(
	.ADDR_W(ADDR_W), .TICK_CYCLES(TICK_CYCLES)
) chk_u (
	.clock, .srst, .address, .read, .write, .writedata, .byteenable, .readdata,
	.waitrequest, .rx_event, .crc_timer_start, .crc_timer_cancel, .crc_timeout, .irq,
	.packet_drop, .link_reset_detect_window, .max_packet_size
);

/* File: sim/rx_link_partner.sv */
// Behavioural far port that delivers one received packet per request
`timescale 1ns/100ps
module rx_link_partner (
	input  wire logic                 clock,
	input  wire logic                 go,
	input  wire logic [3:0]           gap,
	input  wire pd_rx_pkg::rx_event_t pkt,
	output pd_rx_pkg::rx_event_t      ev,
	output logic                      busy
);
	import pd_rx_pkg::*;
	logic [3:0] cnt_q;
	initial begin
		ev = '0;
		busy = 1'b0;
		cnt_q = '0;
	end
	// Flags show the inverse outside the end cycle, so stale sampling is caught
	always @(posedge clock) begin
		ev <= ~pkt;
		ev.sop_start <= 1'b0;
		ev.pkt_done <= 1'b0;
		if (go && !busy) begin
			ev.sop_start <= 1'b1;
			cnt_q <= gap;
			busy <= 1'b1;
		end else if (busy && cnt_q != 4'h0) begin
			cnt_q <= cnt_q - 4'h1;
		end else if (busy) begin
			ev <= pkt;
			ev.pkt_done <= 1'b1;
			busy <= 1'b0;
		end
	end
endmodule // rx_link_partner

/* File: sim/pd_rx_status_tb.sv */
// Self-checking bench for the receive status bank
`timescale 1ns/100ps
`include "pd_rx_regs.svh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin mismatches++; \
	$display("Error at %0t: got %h expected %h", $time, a, e); end end
module pd_rx_status_tb;
	import pd_rx_pkg::*;
	localparam int TK = 4;
	localparam logic [15:0] ST = `IDX_PKT_STAT;
	localparam logic [15:0] TM = `IDX_CRC_TIMEOUT;
	localparam logic [15:0] BC = `IDX_BAD_COUNT;
	localparam logic [15:0] DC = `IDX_DUP_COUNT;
	localparam logic [15:0] WN = `IDX_RESET_WINDOW;
	localparam logic [15:0] MX = `IDX_MAX_SIZE;
	localparam logic [15:0] MD = `IDX_MODE_CTRL;
	logic        clock = 1'b0;
	logic        srst = 1'b1;
	logic [15:0] address = 16'h0;
	logic        read = 1'b0;
	logic        write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [3:0]  byteenable = 4'hF;
	logic [31:0] readdata;
	logic        waitrequest;
	rx_event_t   pkt = '0;
	rx_event_t   ev;
	logic        go = 1'b0;
	logic [3:0]  gap = 4'h0;
	logic        busy;
	logic        tmr_start = 1'b0;
	logic        tmr_cancel = 1'b0;
	logic        crc_timeout;
	rx_irq_t     irq;
	logic        packet_drop;
	logic [6:0]  win;
	logic [7:0]  mxs;
	logic        irq_chk = 1'b0;
	logic [7:0]  exp_b;
	logic [5:0]  exp_i;
	int          mismatches = 0;
	int          num_checks = 0;
	int          seed = 32'h8286A014;
	logic [7:0]  rq[$];
	logic [5:0]  iq[$];
	always #12.5 clock = ~clock;
	pd_rx_status #(.TICK_CYCLES(TK)) dut_u (
		.clock(clock), .srst(srst), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .rx_event(ev), .crc_timer_start(tmr_start),
		.crc_timer_cancel(tmr_cancel), .crc_timeout(crc_timeout), .irq(irq),
		.packet_drop(packet_drop), .link_reset_detect_window(win), .max_packet_size(mxs)
	);
	rx_link_partner peer_u (.clock(clock), .go(go), .gap(gap), .pkt(pkt), .ev(ev), .busy(busy));
	task automatic acc(input logic w, input logic [15:0] i, input logic [7:0] d);
		if (!w) rq.push_back(d);
		address <= i << 2;
		writedata <= {24'h0, d};
		read <= !w;
		write <= w;
		do @(posedge clock); while (waitrequest !== 1'b0);
		read <= 1'b0;
		write <= 1'b0;
		@(posedge clock);
	endtask
	task automatic send(input logic [9:0] f, input logic [7:0] b, input logic [5:0] ie,
			input logic mid);
		if (ie != 6'h0) iq.push_back(ie);
		pkt <= {2'b0, f, b};
		gap <= mid ? 4'hF : 4'($random(seed));
		go <= 1'b1;
		@(posedge clock);
		go <= 1'b0;
		if (mid) begin
			@(posedge clock);
			acc(0, ST, 8'hFF);
		end
		do @(posedge clock); while (busy);
		repeat (2) @(posedge clock);
	endtask
	task automatic pk(input logic [1:0] m, input logic [9:0] f, input logic [7:0] b,
			input logic [7:0] s, input logic [5:0] ie);
		acc(1, MD, {6'h0, m});
		irq_chk <= (m != 2'h0);
		send(f, b, ie, 0);
		acc(0, ST, s);
		acc(1, ST, 8'hFF);
		acc(0, ST, 8'h00);
	endtask
	task automatic tmr(input logic c);
		int n;
		tmr_start <= 1'b1;
		@(posedge clock);
		tmr_start <= 1'b0;
		tmr_cancel <= c;
		@(posedge clock);
		tmr_cancel <= 1'b0;
		n = 1;
		while (crc_timeout !== 1'b1 && n < 120) begin
			@(posedge clock);
			n++;
		end
		`CHK(n >= (2 * `CRC_UNIT_US - 1) * TK && n <= 2 * `CRC_UNIT_US * TK + 2, !c)
	endtask
	task automatic final_report;
		mismatches += rq.size() + iq.size();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Reads compare on the answering edge; interrupts on any non-idle cycle while irq_chk is set
	always @(posedge clock) begin
		if (read && !waitrequest) begin
			exp_b = rq.pop_front();
			`CHK(readdata, {24'h0, exp_b})
		end
		if (irq_chk && {packet_drop, irq} !== 6'h0) begin
			exp_i = iq.pop_front();
			`CHK({packet_drop, irq}, exp_i)
		end
	end
	initial begin
		#(25 * 20000);
		mismatches++;
		final_report;
	end
	initial begin
		logic [7:0] d;
		repeat (4) @(posedge clock);
		srst <= 1'b0;
		@(posedge clock);
		acc(0, ST, 8'h00);
		acc(0, TM, 8'h64);
		acc(0, BC, 8'h00);
		acc(0, DC, 8'h00);
		acc(0, WN, 8'h5E);
		acc(0, MX, 8'h22);
		`CHK({win, mxs}, {`RST_RESET_WINDOW, `RST_MAX_SIZE})
		acc(0, MD, 8'h00);
		acc(0, 16'h1A50, 8'h00);
		pk(2'h0, 10'h300, 8'h22, 8'h00, 6'h00);
		pk(2'h1, 10'h300, 8'h22, 8'h41, 6'h30);
		pk(2'h1, 10'h280, 8'h22, 8'h21, 6'h10);
		pk(2'h1, 10'h210, 8'h22, 8'h10, 6'h28);
		pk(2'h1, 10'h200, 8'h23, 8'h08, 6'h30);
		pk(2'h1, 10'h340, 8'h23, 8'h08, 6'h30);
		pk(2'h1, 10'h240, 8'h22, 8'h01, 6'h10);
		pk(2'h2, 10'h208, 8'h22, 8'h04, 6'h04);
		pk(2'h2, 10'h20A, 8'h22, 8'h00, 6'h00);
		pk(2'h2, 10'h201, 8'h22, 8'h00, 6'h00);
		pk(2'h1, 10'h201, 8'h22, 8'h02, 6'h02);
		pk(2'h1, 10'h310, 8'h22, 8'h51, 6'h38);
		send(10'h240, 8'h22, 6'h10, 1);
		send(10'h300, 8'h22, 6'h30, 0);
		acc(0, ST, 8'h01);
		acc(1, ST, 8'h00);
		acc(0, ST, 8'h01);
		acc(1, BC, 8'h00);
		repeat (127) send(10'h240, 8'h22, 6'h10, 0);
		acc(0, BC, 8'h7F);
		send(10'h240, 8'h22, 6'h11, 0);
		acc(0, BC, 8'h80);
		acc(1, BC, 8'($random(seed)));
		acc(0, BC, 8'h00);
		send(10'h280, 8'h22, 6'h10, 0);
		send(10'h040, 8'h22, 6'h10, 0);
		send(10'h220, 8'h22, 6'h00, 0);
		acc(0, BC, 8'h02);
		acc(1, MD, 8'h05);
		irq_chk <= 1'b0;
		send(10'h240, 8'h22, 6'h00, 0);
		acc(0, BC, 8'h02);
		acc(1, MD, 8'h01);
		acc(1, DC, 8'h00);
		irq_chk <= 1'b1;
		send(10'h201, 8'h22, 6'h02, 0);
		acc(0, DC, 8'h01);
		acc(1, MD, 8'h02);
		send(10'h201, 8'h22, 6'h00, 0);
		acc(0, DC, 8'h01);
		acc(1, TM, 8'h02);
		acc(0, TM, 8'h02);
		tmr(0);
		tmr(1);
		d = 8'($random(seed));
		acc(1, WN, d);
		`CHK(win, d[6:0])
		acc(0, WN, {1'b0, d[6:0]});
		acc(1, MX, d);
		byteenable <= 4'hE;
		acc(1, MX, ~d);
		byteenable <= 4'hF;
		acc(0, MX, d);
		`CHK(mxs, d)
		acc(1, 16'h1A50, 8'hFF);
		acc(0, 16'h1A50, 8'h00);
		final_report;
	end
endmodule // pd_rx_status_tb
